// *** core/rss_pkg.sv ***
// Package for the reset and suspend sequencer: offsets, fields, timing, types
package rss_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] RSS_WATCHDOG_CLEAR_ADDR = 8'h26;
    localparam logic [7:0] RSS_STATUS_ADDR = 8'hff;
    localparam logic [7:0] RSS_CLOCK_CFG_ADDR = 8'hf8;
    // Status register fields
    localparam int RSS_ST_RUN_BIT = 0;
    localparam int RSS_ST_IE_SENSE_BIT = 2;
    localparam int RSS_ST_SUSPEND_BIT = 3;
    localparam int RSS_ST_LVR_BOR_BIT = 4;
    localparam int RSS_ST_WATCHDOG_BIT = 6;
    localparam logic [7:0] RSS_STATUS_RESET = 8'h01;
    // Clock configuration fields
    localparam int RSS_CC_EXT_OSC_BIT = 0;
    localparam int RSS_CC_LVR_DISABLE_BIT = 3;
    localparam int RSS_CC_EXT_DELAY_BIT = 7;
    localparam logic [7:0] RSS_CLOCK_CFG_RESET = 8'h00;
    localparam logic [7:0] RSS_CC_MASK = 8'h89;
    localparam logic [15:0] RSS_RESET_VECTOR = 16'h0000;
    // ------------------------------------------------------------
    // Timing (clock 10 MHz)
    // ------------------------------------------------------------
    localparam int RSS_CLK_KHZ = 10000;
    localparam int RSS_INT_WAKE_US = 8;
    localparam int RSS_EXT_SHORT_US = 128;
    localparam int RSS_EXT_LONG_MS = 4;
    localparam int RSS_WDR_HOLD_MS = 3;
    localparam int RSS_INT_WAKE_CYC = RSS_INT_WAKE_US * RSS_CLK_KHZ / 1000;
    localparam int RSS_EXT_SHORT_CYC = RSS_EXT_SHORT_US * RSS_CLK_KHZ / 1000;
    localparam int RSS_EXT_LONG_CYC = RSS_EXT_LONG_MS * RSS_CLK_KHZ;
    localparam int RSS_WDR_HOLD_CYC = RSS_WDR_HOLD_MS * RSS_CLK_KHZ;
    localparam int RSS_CNT_W = 24;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RSS_POWER_RESET,
        RSS_STARTUP,
        RSS_RUN,
        RSS_WATCHDOG_HOLD,
        RSS_SUSPEND,
        RSS_OSC_WAIT,
        RSS_RESUME_DELAY
    } rss_phase_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rss_io_t;

    typedef struct packed {
        rss_phase_t phase;
        logic [RSS_CNT_W-1:0] delay;
        logic [RSS_CNT_W-1:0] watchdog;
        logic [7:0] status;
        logic [7:0] clock_cfg;
        logic ext_mode;
        logic lvr_before_suspend;
        logic lvr_event;
        logic [7:0] rdata;
        logic fetch;
        logic [1:0] sync_lvr;
        logic [1:0] sync_bor;
        logic [1:0] sync_osc;
        logic [1:0] sync_dline;
    } rss_state_t;
endpackage : rss_pkg

// *** core/rss_sequencer.sv ***
// Reset, watchdog and suspend sequencer of the microcontroller core
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer #(
    parameter int STARTUP_CYC = 10000,
    parameter int WATCHDOG_CYC = 80000,
    parameter int WDR_HOLD_CYC = rss_pkg::RSS_WDR_HOLD_CYC,
    parameter int EXT_LONG_CYC = rss_pkg::RSS_EXT_LONG_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // CPU I/O access
    input wire rss_pkg::rss_io_t io,
    output logic [7:0] io_rdata,
    // Analog comparators and pins
    input wire logic supply_below_low_threshold,
    input wire logic supply_below_brownout,
    input wire logic ext_osc_stable,
    input wire logic usb_minus_ps2_data_line,
    // Wake sources (enabled and pending)
    input wire logic gpio_irq_pending,
    input wire logic wake_timer_irq_pending,
    input wire logic spi_slave_irq_pending,
    // Core control
    output logic core_reset,
    output logic core_run,
    output logic fetch_reset_vector,
    output logic suspended,
    output logic int_osc_on,
    output logic ext_osc_on,
    output logic watchdog_running,
    output logic low_voltage_reset_active
);
    import rss_pkg::*;

    rss_state_t q;
    rss_state_t next_q;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Counter load value clamped to at least one cycle
    function automatic logic [RSS_CNT_W-1:0] cyc(input int n);
        cyc = (n < 1) ? RSS_CNT_W'(1) : RSS_CNT_W'(n);
    endfunction : cyc

    // Post-stability delay chosen by the resume delay bit
    function automatic logic [RSS_CNT_W-1:0] ext_delay(input logic [7:0] cc);
        ext_delay = cc[RSS_CC_EXT_DELAY_BIT] ? cyc(EXT_LONG_CYC) : cyc(RSS_EXT_SHORT_CYC);
    endfunction : ext_delay

    logic lvr_low;
    logic bor_low;
    logic osc_ok;
    logic dline_low;
    logic lvr_enabled;
    logic wake;
    logic io_hit_wd;
    logic io_hit_st;
    logic io_hit_cc;

    always_comb begin
        lvr_low = q.sync_lvr[1];
        bor_low = q.sync_bor[1];
        osc_ok = q.sync_osc[1];
        dline_low = ~q.sync_dline[1];
        lvr_enabled = ~q.clock_cfg[RSS_CC_LVR_DISABLE_BIT];
        // Wake sources, sense bit deliberately not consulted
        wake = gpio_irq_pending | wake_timer_irq_pending | spi_slave_irq_pending | dline_low;
        io_hit_wd = io.write && (io.addr == RSS_WATCHDOG_CLEAR_ADDR);
        io_hit_st = io.write && (io.addr == RSS_STATUS_ADDR);
        io_hit_cc = io.write && (io.addr == RSS_CLOCK_CFG_ADDR);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.fetch = 1'b0;
        // Comparator and pin inputs are asynchronous to clk
        next_q.sync_lvr = {q.sync_lvr[0], supply_below_low_threshold};
        next_q.sync_bor = {q.sync_bor[0], supply_below_brownout};
        next_q.sync_osc = {q.sync_osc[0], ext_osc_stable};
        next_q.sync_dline = {q.sync_dline[0], usb_minus_ps2_data_line};
        if (q.delay != '0) begin
            next_q.delay = q.delay - RSS_CNT_W'(1);
        end
        // Read path
        if (io.read && io.addr == RSS_STATUS_ADDR) begin
            next_q.rdata = q.status;
        end else if (io.read && io.addr == RSS_CLOCK_CFG_ADDR) begin
            next_q.rdata = q.clock_cfg;
        end else begin
            next_q.rdata = 8'h00; // Watchdog clear is write-only
        end
        // Firmware writes; cause bits are sticky and cleared by writing zero
        if (io_hit_cc && q.phase == RSS_RUN) begin
            next_q.clock_cfg = io.wdata & RSS_CC_MASK;
            if (io.wdata[RSS_CC_EXT_OSC_BIT] && !q.ext_mode) begin
                next_q.ext_mode = 1'b1;
                next_q.phase = RSS_OSC_WAIT;
            end
        end
        if (io_hit_st && q.phase == RSS_RUN) begin
            next_q.status = io.wdata;
            if (io.wdata[RSS_ST_SUSPEND_BIT] && io.wdata[RSS_ST_RUN_BIT]) begin
                // Entered even if a wake source is already present
                next_q.lvr_before_suspend = lvr_enabled;
                next_q.phase = RSS_SUSPEND;
            end
        end
        // Watchdog
        if (q.phase == RSS_RUN) begin
            if (io_hit_wd) begin
                next_q.watchdog = '0;
            end else if (q.watchdog >= cyc(WATCHDOG_CYC) - RSS_CNT_W'(1)) begin
                next_q.watchdog = '0;
                next_q.status[RSS_ST_WATCHDOG_BIT] = 1'b1;
                next_q.delay = cyc(WDR_HOLD_CYC);
                next_q.phase = RSS_WATCHDOG_HOLD;
            end else begin
                next_q.watchdog = q.watchdog + RSS_CNT_W'(1);
            end
        end
        // Sequencing
        case (q.phase)
            RSS_POWER_RESET: begin
                if (!lvr_low && !bor_low) begin
                    next_q.delay = cyc(STARTUP_CYC);
                    next_q.phase = RSS_STARTUP;
                end
            end
            RSS_STARTUP, RSS_WATCHDOG_HOLD: begin
                if (q.delay == RSS_CNT_W'(1) || q.delay == '0) begin
                    next_q.phase = RSS_RUN;
                    next_q.fetch = 1'b1;
                    next_q.watchdog = '0;
                end
            end
            RSS_SUSPEND: begin
                // Watchdog frozen here; only the wake sources and brown-out are watched
                if (wake) begin
                    next_q.ext_mode = q.clock_cfg[RSS_CC_EXT_OSC_BIT];
                    if (q.clock_cfg[RSS_CC_EXT_OSC_BIT]) begin
                        next_q.phase = RSS_OSC_WAIT;
                    end else begin
                        next_q.delay = cyc(RSS_INT_WAKE_CYC);
                        next_q.phase = RSS_RESUME_DELAY;
                    end
                end
            end
            RSS_OSC_WAIT: begin
                if (osc_ok) begin
                    next_q.delay = ext_delay(q.clock_cfg);
                    next_q.phase = RSS_RESUME_DELAY;
                end
            end
            RSS_RESUME_DELAY: begin
                if (q.delay == RSS_CNT_W'(1) || q.delay == '0) begin
                    // Continues after the suspend write; no vector fetch
                    next_q.status[RSS_ST_SUSPEND_BIT] = 1'b0;
                    next_q.phase = RSS_RUN;
                end
            end
            default: begin
                // Run: the watchdog and register writes above already chose the next phase
            end
        endcase
        // Supply resets override phase, clock mode, registers and counters, but not a fetch pulse set above; the cause bit is set last so it wins
        if (bor_low || (lvr_low && lvr_enabled && q.phase != RSS_SUSPEND)) begin
            next_q.phase = RSS_POWER_RESET;
            next_q.clock_cfg = RSS_CLOCK_CFG_RESET;
            next_q.ext_mode = 1'b0;
            next_q.status = RSS_STATUS_RESET;
            next_q.status[RSS_ST_LVR_BOR_BIT] = 1'b1;
            next_q.watchdog = '0;
            next_q.delay = '0;
        end
        if (q.phase == RSS_WATCHDOG_HOLD && next_q.phase == RSS_WATCHDOG_HOLD) begin
            // Clock mode kept; clock configuration cleared, and only the suspend bit of status cleared
            next_q.clock_cfg = RSS_CLOCK_CFG_RESET;
            next_q.status[RSS_ST_SUSPEND_BIT] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.phase <= RSS_POWER_RESET;
            q.status <= RSS_STATUS_RESET;
            q.clock_cfg <= RSS_CLOCK_CFG_RESET;
            q.sync_dline <= 2'b11;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Brown-out and start-up hold the core; a watchdog hold does too
    always_comb begin
        io_rdata = q.rdata;
        core_reset = (q.phase == RSS_POWER_RESET) || (q.phase == RSS_STARTUP) ||
                     (q.phase == RSS_WATCHDOG_HOLD);
        core_run = (q.phase == RSS_RUN);
        fetch_reset_vector = q.fetch;
        suspended = (q.phase == RSS_SUSPEND);
        int_osc_on = !q.ext_mode && (q.phase != RSS_SUSPEND);
        ext_osc_on = q.ext_mode && (q.phase != RSS_SUSPEND);
        watchdog_running = (q.phase == RSS_RUN);
        low_voltage_reset_active = lvr_enabled && (q.phase != RSS_SUSPEND);
    end
endmodule : rss_sequencer
`default_nettype wire

// *** tb/rss_checker_assertions.sv ***
// Concurrent checks on the ports of the reset and suspend sequencer
`timescale 1ns/1ps
`default_nettype none
module rss_checker
    import rss_pkg::*;
#(
    parameter int WATCHDOG_CYC = 80000
) (
    // Clock, reset and inputs
    input wire logic clk,
    input wire logic reset,
    input wire rss_pkg::rss_io_t io,
    input wire logic supply_below_low_threshold,
    input wire logic supply_below_brownout,
    // Watched outputs
    input wire logic [7:0] io_rdata,
    input wire logic core_reset,
    input wire logic core_run,
    input wire logic fetch_reset_vector,
    input wire logic suspended,
    input wire logic int_osc_on,
    input wire logic ext_osc_on,
    input wire logic watchdog_running,
    input wire logic low_voltage_reset_active
);
    logic [23:0] wd_age;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Age since last clear; restarting when stopped can only undercount, never false-fire
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_age <= 24'h000000;
        end else if (!watchdog_running || (io.write && io.addr == RSS_WATCHDOG_CLEAR_ADDR)) begin
            wd_age <= 24'h000000;
        end else begin
            wd_age <= wd_age + 24'h000001;
        end
    end
    chk_run_not_reset: assert property (core_run |-> !core_reset)
        else $error("core runs while held in reset");
    chk_susp_clocks_off: assert property (suspended |-> !int_osc_on && !ext_osc_on && !watchdog_running)
        else $error("clock or watchdog alive in suspend");
    chk_susp_lv_off: assert property (suspended |-> !low_voltage_reset_active)
        else $error("low voltage reset active in suspend");
    chk_brown_resets: assert property (supply_below_brownout [*3] |-> ##[1:2] core_reset)
        else $error("brown-out did not reset");
    chk_low_resets: assert property ((supply_below_low_threshold && low_voltage_reset_active) [*3]
        |-> ##[1:2] core_reset)
        else $error("low supply did not reset");
    chk_fetch_pulse: assert property (fetch_reset_vector |=> !fetch_reset_vector)
        else $error("fetch pulse longer than one cycle");
    chk_fetch_then_run: assert property (fetch_reset_vector |-> ##[0:2] core_run)
        else $error("fetch not followed by run");
    chk_wd_bound: assert property (int'(wd_age) <= WATCHDOG_CYC + 3)
        else $error("watchdog not expired in time");
    chk_clear_wo_read: assert property (io.read && io.addr == RSS_WATCHDOG_CLEAR_ADDR
        |=> io_rdata == 8'h00)
        else $error("watchdog clear register readable");
endmodule : rss_checker
bind rss_sequencer rss_checker #(.WATCHDOG_CYC(WATCHDOG_CYC)) u_rss_checker (.clk(clk),
    .reset(reset), .io(io), .supply_below_low_threshold(supply_below_low_threshold),
    .supply_below_brownout(supply_below_brownout), .io_rdata(io_rdata), .core_reset(core_reset),
    .core_run(core_run), .fetch_reset_vector(fetch_reset_vector), .suspended(suspended),
    .int_osc_on(int_osc_on), .ext_osc_on(ext_osc_on), .watchdog_running(watchdog_running),
    .low_voltage_reset_active(low_voltage_reset_active));
`default_nettype wire

// *** tb/tb_rss_sequencer.sv ***
// Self-checking testbench for the reset and suspend sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_rss_sequencer;
    import rss_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, reset, low, brown, osc_ok, dline, gpio, wtmr, spi;
    rss_io_t io;
    logic [7:0] io_rdata, rd_val;
    logic core_reset, core_run, fetch, susp, int_osc, ext_osc, wd_run, lv_active;
    logic fetch_seen, susp_seen;
    int n_errors = 0, check_count = 0, n;
    // Short counts keep the run brief
    rss_sequencer #(.STARTUP_CYC(20), .WATCHDOG_CYC(200), .WDR_HOLD_CYC(10), .EXT_LONG_CYC(30))
    u_rss_sequencer (.clk(clk), .reset(reset), .io(io), .io_rdata(io_rdata),
        .supply_below_low_threshold(low), .supply_below_brownout(brown),
        .ext_osc_stable(osc_ok), .usb_minus_ps2_data_line(dline), .gpio_irq_pending(gpio),
        .wake_timer_irq_pending(wtmr), .spi_slave_irq_pending(spi), .core_reset(core_reset),
        .core_run(core_run), .fetch_reset_vector(fetch), .suspended(susp), .int_osc_on(int_osc),
        .ext_osc_on(ext_osc), .watchdog_running(wd_run), .low_voltage_reset_active(lv_active));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // One register access; outputs are sampled mid-cycle to avoid edge races
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        io <= '{write: w, read: !w, addr: a, wdata: d};
        @(posedge clk);
        io <= '0;
        @(negedge clk);
        rd_val = io_rdata;
    endtask : acc
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_run(input int lim);
        n = 0;
        while (core_run !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("run reached", 8'h01, {7'h00, core_run});
    endtask : wait_run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // Clock, flags and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Pulses may last one cycle; latched on their own edge so a mid-cycle look sees them
    always @(posedge fetch) fetch_seen = 1'b1;
    always @(posedge susp) susp_seen = 1'b1;
    initial begin
        #1000000;
        n_errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {reset, low, brown, osc_ok, gpio, wtmr, spi} = 7'b1000000;
        dline = 1'b1;
        io = '0;
        fetch_seen = 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        wait_run(100);
        chk("startup delay", 8'h01, {7'h00, n >= 20});
        chk("startup fetch", 8'h01, {7'h00, fetch_seen});
        acc(1'b0, RSS_STATUS_ADDR, 8'h00);
        chk("status reset", RSS_STATUS_RESET, rd_val);
        acc(1'b0, RSS_WATCHDOG_CLEAR_ADDR, 8'h00);
        chk("clear read", 8'h00, rd_val);
        $display("test startup done");
        repeat (3) begin
            acc(1'b1, RSS_WATCHDOG_CLEAR_ADDR, 8'h5a);
            cyc(150);
        end
        chk("cleared run", 8'h01, {7'h00, core_run});
        fetch_seen = 1'b0;
        n = 0;
        while (core_reset !== 1'b1 && n < 260) begin
            @(negedge clk);
            n++;
        end
        // Count starts 150 cycles after the last clear
        chk("wd expiry", 8'h01, {7'h00, n + 150 >= 190 && n + 150 <= 205});
        wait_run(40);
        chk("wd hold", 8'h01, {7'h00, n >= 9 && n <= 14});
        chk("wd fetch", 8'h01, {7'h00, fetch_seen});
        acc(1'b0, RSS_STATUS_ADDR, 8'h00);
        chk("wd cause", 8'h40, rd_val & 8'h40);
        $display("test watchdog done");
        acc(1'b1, RSS_STATUS_ADDR, 8'h01);
        @(posedge clk) low <= 1'b1;
        cyc(5);
        chk("low reset", 8'h01, {7'h00, core_reset});
        @(posedge clk) low <= 1'b0;
        wait_run(60);
        chk("low restart", 8'h01, {7'h00, n >= 20});
        acc(1'b0, RSS_STATUS_ADDR, 8'h00);
        chk("low cause", 8'h10, rd_val & 8'h10);
        acc(1'b1, RSS_CLOCK_CFG_ADDR, 8'h08);
        @(posedge clk) low <= 1'b1;
        cyc(10);
        chk("low disabled", 8'h01, {7'h00, core_run});
        @(posedge clk) brown <= 1'b1;
        cyc(5);
        chk("brown reset", 8'h01, {7'h00, core_reset});
        @(posedge clk) brown <= 1'b0;
        cyc(10);
        chk("brown holds", 8'h01, {7'h00, core_reset});
        @(posedge clk) low <= 1'b0;
        wait_run(60);
        acc(1'b0, RSS_CLOCK_CFG_ADDR, 8'h00);
        chk("brown reenable", 8'h00, rd_val);
        chk("low active", 8'h01, {7'h00, lv_active});
        $display("test supply done");
        fetch_seen = 1'b0;
        acc(1'b1, RSS_STATUS_ADDR, 8'h09);
        chk("suspended", 8'h01, {7'h00, susp});
        chk("susp wd stopped", 8'h00, {7'h00, wd_run});
        chk("susp low off", 8'h00, {7'h00, lv_active});
        @(posedge clk) low <= 1'b1;
        cyc(5);
        chk("susp ignores low", 8'h01, {7'h00, susp});
        @(posedge clk) low <= 1'b0;
        @(posedge clk) gpio <= 1'b1;
        wait_run(200);
        @(posedge clk) gpio <= 1'b0;
        chk("int wake delay", 8'h01, {7'h00, n >= 78 && n <= 90});
        chk("no fetch", 8'h00, {7'h00, fetch_seen});
        chk("low restored", 8'h01, {7'h00, lv_active});
        chk("int osc on", 8'h01, {7'h00, int_osc});
        susp_seen = 1'b0;
        @(posedge clk) wtmr <= 1'b1;
        acc(1'b1, RSS_STATUS_ADDR, 8'h09);
        wait_run(200);
        @(posedge clk) wtmr <= 1'b0;
        chk("early wake", 8'h01, {7'h00, susp_seen});
        $display("test suspend done");
        acc(1'b1, RSS_CLOCK_CFG_ADDR, 8'h01);
        cyc(5);
        chk("osc wait", 8'h02, {6'h00, ext_osc, core_run});
        @(posedge clk) osc_ok <= 1'b1;
        wait_run(1400);
        chk("short delay", 8'h01, {7'h00, n >= 1280});
        acc(1'b1, RSS_CLOCK_CFG_ADDR, 8'h81);
        @(posedge clk) osc_ok <= 1'b0;
        acc(1'b1, RSS_STATUS_ADDR, 8'h09);
        @(posedge clk) dline <= 1'b0;
        cyc(10);
        chk("ext wake wait", 8'h02, {6'h00, ext_osc, core_run});
        @(posedge clk);
        osc_ok <= 1'b1;
        dline <= 1'b1;
        wait_run(100);
        chk("long delay", 8'h01, {7'h00, n >= 29 && n <= 40});
        acc(1'b1, RSS_STATUS_ADDR, 8'h09);
        @(posedge clk) spi <= 1'b1;
        wait_run(1400);
        @(posedge clk) spi <= 1'b0;
        $display("test clocking done");
        tally_and_finish();
    end
endmodule : tb_rss_sequencer
`default_nettype wire
